// >>> src/wdc_pkg.sv
package wdc_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] COUNT_OFS     = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h0c;
  localparam logic [7:0] TICK_DIV_OFS  = 8'h10;
  // ----------------------------------------
  // Control/status field positions
  // ----------------------------------------
  localparam int RUN_POS       = 2;
  localparam int RUN_GUARD_POS = 3;
  localparam int RST_GUARD_POS = 1;
  localparam int FLAG_POS      = 0;
  localparam int WEN_POS       = 4;
  // ----------------------------------------
  // Reset values and counter maximum
  // ----------------------------------------
  localparam logic [7:0]  COUNT_RST    = 8'h00;
  localparam logic [7:0]  COUNT_MAX    = 8'hff;
  localparam logic [15:0] TICK_DIV_RST = 16'h0000;
  localparam logic        IRQ_MASK_RST = 1'b0;
  // ----------------------------------------
  // AHB encodings
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage : wdc_pkg

// >>> src/wdc_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdc_tick_if;
  logic [15:0] div;
  logic        tick;
  modport gen (input div, output tick);
  modport use_ (output div, input tick);
endinterface : wdc_tick_if
`default_nettype wire

// >>> src/wdc_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Count clock divider
// ----------------------------------------
module wdc_tick_gen (
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  wdc_tick_if.gen    tk
);
  logic [15:0] cnt;

  // Divide value 0 gives a tick every system clock
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt     <= 16'h0000;
      tk.tick <= 1'b0;
    end else if (cnt >= tk.div) begin
      cnt     <= 16'h0000;
      tk.tick <= 1'b1;
    end else begin
      cnt     <= cnt + 16'h0001;
      tk.tick <= 1'b0;
    end
  end
endmodule : wdc_tick_gen
`default_nettype wire

// >>> src/wdc_top.sv
// Behaviour
// [R1] Counter advances only while run bit set
// [R2] Run sets on guarded enabled write of 1
// [R3] Run clears on reset or guarded write 0
// [R4] Flag written only with guard zero; guard reads 1
// [R5] Flag sets on counter overflow reset
// [R6] Flag clears on reset or guarded write 0
// [R7] Counter is 8-bit, readable and writable
// [R8] Wrap from max to zero asserts reset
// [R9] Counter is zero after reset
// [R10] Counter steps once per count tick
`timescale 1ns/1ps
`default_nettype none
module wdc_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic             o_wdt_reset,
  output logic             o_irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic       count_run;
  logic       overflow_reset_flag;
  logic       control_write_enable;
  logic [7:0] watchdog_count;
  logic       irq_stat;
  logic       irq_mask;
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       overflow;
  logic       wr_ctrl;
  logic       wr_count;
  logic [7:0] wd;

  wdc_tick_if tk ();

  wdc_tick_gen u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .tk      (tk)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  logic addr_ok;
  assign addr_ok = i_hsel && i_hready && (i_htrans == wdc_pkg::HTRANS_NONSEQ ||
                   i_htrans == wdc_pkg::HTRANS_SEQ);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && i_hwrite;
      if (addr_ok) begin
        wr_addr <= i_haddr;
      end
    end
  end

  assign wd       = i_hwdata[7:0];
  assign wr_ctrl  = wr_pend && hit(wr_addr, wdc_pkg::CTRL_OFS);
  assign wr_count = wr_pend && hit(wr_addr, wdc_pkg::COUNT_OFS);

  // Read data registered in the address phase; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_ok && !i_hwrite) begin
      case (i_haddr)
        // Both guards store nothing and read as one
        wdc_pkg::CTRL_OFS: begin
          o_hrdata <= {27'h0, control_write_enable, 1'b1, count_run, 1'b1, // [R4]
                       overflow_reset_flag};
        end
        wdc_pkg::COUNT_OFS:    o_hrdata <= {24'h000000, watchdog_count}; // [R7]
        wdc_pkg::IRQ_STAT_OFS: o_hrdata <= {31'h00000000, irq_stat};
        wdc_pkg::IRQ_MASK_OFS: o_hrdata <= {31'h00000000, irq_mask};
        wdc_pkg::TICK_DIV_OFS: o_hrdata <= {16'h0000, tk.div};
        default:               o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      control_write_enable <= 1'b0;
    end else if (wr_ctrl) begin
      control_write_enable <= wd[wdc_pkg::WEN_POS];
    end
  end

  // Enable is sampled before this write updates it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      count_run <= 1'b0; // [R3]
    end else if (wr_ctrl && control_write_enable && !wd[wdc_pkg::RUN_GUARD_POS]) begin
      count_run <= wd[wdc_pkg::RUN_POS]; // [R2] [R3]
    end
  end

  // Overflow set wins over a clearing write in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      overflow_reset_flag <= 1'b0; // [R6]
    end else if (overflow) begin
      overflow_reset_flag <= 1'b1; // [R5]
    end else if (wr_ctrl && control_write_enable && !wd[wdc_pkg::RST_GUARD_POS]) begin
      overflow_reset_flag <= wd[wdc_pkg::FLAG_POS]; // [R4] [R6]
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  assign overflow = count_run && tk.tick && !wr_count &&
                    (watchdog_count == wdc_pkg::COUNT_MAX); // [R8]

  // Software write takes priority over a tick
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      watchdog_count <= wdc_pkg::COUNT_RST; // [R9]
    end else if (wr_count) begin
      watchdog_count <= wd; // [R7]
    end else if (count_run && tk.tick) begin
      watchdog_count <= watchdog_count + 8'h01; // [R1] [R10]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_wdt_reset <= 1'b0;
    end else begin
      o_wdt_reset <= overflow; // [R8]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tk.div <= wdc_pkg::TICK_DIV_RST;
    end else if (wr_pend && hit(wr_addr, wdc_pkg::TICK_DIV_OFS)) begin
      tk.div <= i_hwdata[15:0];
    end
  end

  // ----------------------------------------
  // Interrupt, write one to clear
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_stat <= 1'b0;
    end else if (overflow) begin
      irq_stat <= 1'b1;
    end else if (wr_pend && hit(wr_addr, wdc_pkg::IRQ_STAT_OFS) && i_hwdata[0]) begin
      irq_stat <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_mask <= wdc_pkg::IRQ_MASK_RST;
    end else if (wr_pend && hit(wr_addr, wdc_pkg::IRQ_MASK_OFS)) begin
      irq_mask <= i_hwdata[0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (irq_stat || overflow) && irq_mask;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence run_tick_s;
    count_run && tk.tick && !wr_count;
  endsequence

  run_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R1]
    run_tick_s |=> watchdog_count == $past(watchdog_count) + 8'h01)
    else $error("Counter did not step while running");

  halt_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R1]
    (!count_run && !wr_count) |=> $stable(watchdog_count))
    else $error("Counter moved while halted");

  run_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2]
    (wr_ctrl && control_write_enable && !wd[wdc_pkg::RUN_GUARD_POS] &&
     wd[wdc_pkg::RUN_POS]) |=> count_run)
    else $error("Run bit not set");

  run_guard_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R3]
    (!(wr_ctrl && control_write_enable)) |=> $stable(count_run))
    else $error("Run bit changed without enabled write");

  flag_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R5]
    overflow |=> overflow_reset_flag && o_wdt_reset)
    else $error("Overflow did not set flag and reset");

  flag_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R6]
    (!overflow && !(wr_ctrl && control_write_enable && !wd[wdc_pkg::RST_GUARD_POS])) |=>
    $stable(overflow_reset_flag))
    else $error("Flag changed without cause");

  wrap_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R8]
    overflow |=> watchdog_count == 8'h00 ##1 !o_wdt_reset || overflow)
    else $error("Wrap did not reach zero");

  count_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R7]
    wr_count |=> watchdog_count == $past(wd))
    else $error("Counter write lost");

  reset_zero_a: assert property (@(posedge i_clk) // [R9]
    !i_rst_n |=> watchdog_count == 8'h00 && !count_run && !overflow_reset_flag)
    else $error("Reset state wrong");

  // ----------------------------------------
  // Guard, pulse, tick, enable, interrupt and bus checks
  // ----------------------------------------
  run_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R2]
    (wr_ctrl && wd[wdc_pkg::RUN_GUARD_POS]) |=> $stable(count_run))
    else $error("Guarded write moved run bit");

  run_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R3]
    (wr_ctrl && control_write_enable && !wd[wdc_pkg::RUN_GUARD_POS] &&
     !wd[wdc_pkg::RUN_POS]) |=> !count_run)
    else $error("Run bit not cleared");

  flag_guard_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R4]
    (!overflow && wr_ctrl && wd[wdc_pkg::RST_GUARD_POS]) |=>
    $stable(overflow_reset_flag))
    else $error("Guarded write moved flag");

  // Guard bit has no storage, so only the read path can show it
  guard_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R4]
    (addr_ok && !i_hwrite && hit(i_haddr, wdc_pkg::CTRL_OFS)) |=>
    o_hrdata[wdc_pkg::RST_GUARD_POS])
    else $error("Flag guard did not read one");

  flag_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R6]
    (!overflow && wr_ctrl && control_write_enable && !wd[wdc_pkg::RST_GUARD_POS] &&
     !wd[wdc_pkg::FLAG_POS]) |=> !overflow_reset_flag)
    else $error("Flag not cleared");

  reset_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R8]
    o_wdt_reset |=> !o_wdt_reset)
    else $error("Internal reset longer than one cycle");

  tick_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [R10]
    (!tk.tick && !wr_count) |=> $stable(watchdog_count))
    else $error("Counter moved without a tick");

  wen_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_ctrl |=> control_write_enable == $past(wd[wdc_pkg::WEN_POS]))
    else $error("Write enable bit not stored");

  irq_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    overflow |=> irq_stat)
    else $error("Overflow did not set status");

  irq_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!overflow && wr_pend && hit(wr_addr, wdc_pkg::IRQ_STAT_OFS) && i_hwdata[0]) |=>
    !irq_stat)
    else $error("Status not cleared by write one");

  irq_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (irq_stat && irq_mask) |=> o_irq)
    else $error("Unmasked status without interrupt");

  irq_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !irq_mask |=> !o_irq)
    else $error("Masked interrupt raised");

  bus_okay_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_hreadyout && !o_hresp)
    else $error("Bus response not ready and okay");
endmodule : wdc_top
`default_nettype wire

// >>> testbench/tb_watchdog_counter_reset_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_counter_reset_control;
  // ----------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------
  localparam logic [31:0] EN  = 32'h1 << wdc_pkg::WEN_POS;
  localparam logic [31:0] RUN = 32'h1 << wdc_pkg::RUN_POS;
  localparam logic [31:0] RWG = 32'h1 << wdc_pkg::RUN_GUARD_POS;
  localparam logic [31:0] RG  = 32'h1 << wdc_pkg::RST_GUARD_POS;
  localparam logic [31:0] FL  = 32'h1 << wdc_pkg::FLAG_POS;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        wdt_rst;
  logic        irq;
  logic [31:0] r;
  logic [31:0] r2;
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #2 clk = ~clk;

  wdc_top i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .o_wdt_reset(wdt_rst), .o_irq(irq)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Waits on hready rather than a fixed latency
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= wdc_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(wdc_pkg::COUNT_OFS, r);
    chk("count", 32'h0, r);
    rd(wdc_pkg::CTRL_OFS, r);
    chk("ctrl", RWG | RG, r & (EN | RWG | RUN | RG | FL));
    rd(8'h20, r);
    chk("unmapped", 32'h0, r);
    $display("test reset done");
  endtask : t_reset

  task automatic t_count_rw;
    wr(wdc_pkg::COUNT_OFS, 32'h5a);
    repeat (10) @(posedge clk);
    rd(wdc_pkg::COUNT_OFS, r);
    chk("held count", 32'h5a, r);
    $display("test count rw done");
  endtask : t_count_rw

  // Guard at one, or enable at zero, must leave the run bit alone
  task automatic t_run_guard;
    wr(wdc_pkg::CTRL_OFS, EN);
    wr(wdc_pkg::CTRL_OFS, RUN | RWG);
    rd(wdc_pkg::CTRL_OFS, r);
    chk("guarded run", 32'h0, r & RUN);
    wr(wdc_pkg::CTRL_OFS, RUN);
    rd(wdc_pkg::CTRL_OFS, r);
    chk("locked run", 32'h0, r & RUN);
    rd(wdc_pkg::COUNT_OFS, r);
    chk("idle count", 32'h5a, r);
    $display("test run guard done");
  endtask : t_run_guard

  task automatic t_overflow;
    int n;
    wr(wdc_pkg::COUNT_OFS, 32'hf0);
    wr(wdc_pkg::CTRL_OFS, EN);
    wr(wdc_pkg::CTRL_OFS, RUN);
    // Pulse lasts one cycle, so it is watched at the falling edge
    n = 0;
    while (wdt_rst !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk("wdt reset", 32'h1, {31'h0, wdt_rst});
    // Sixteen ticks from f0, plus the falling edge right after run is set
    chk("ticks to wrap", 32'h11, n);
    chk("masked irq", 32'h0, {31'h0, irq});
    @(posedge clk);
    rd(wdc_pkg::CTRL_OFS, r);
    chk("flag set", FL, r & FL);
    // Run guard at zero with run 0 stops the counter; flag guard at one keeps the flag
    wr(wdc_pkg::CTRL_OFS, EN);
    wr(wdc_pkg::CTRL_OFS, RG);
    rd(wdc_pkg::CTRL_OFS, r);
    chk("run cleared", 32'h0, r & RUN);
    chk("flag kept", FL, r & FL);
    rd(wdc_pkg::COUNT_OFS, r);
    repeat (5) @(posedge clk);
    rd(wdc_pkg::COUNT_OFS, r2);
    chk("stopped count", r, r2);
    $display("test overflow done");
  endtask : t_overflow

  task automatic t_flag;
    // Enable first, so the guarded write really meets enable set
    wr(wdc_pkg::CTRL_OFS, EN);
    wr(wdc_pkg::CTRL_OFS, EN | RG);
    rd(wdc_pkg::CTRL_OFS, r);
    chk("guarded flag", FL, r & FL);
    wr(wdc_pkg::CTRL_OFS, 32'h0);
    rd(wdc_pkg::CTRL_OFS, r);
    chk("cleared flag", 32'h0, r & FL);
    $display("test flag done");
  endtask : t_flag

  task automatic t_irq;
    wr(wdc_pkg::IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(wdc_pkg::IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask : t_irq

  // ----------------------------------------
  // Closing and sequence
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_count_rw();
    t_run_guard();
    t_overflow();
    t_flag();
    t_irq();
    report_and_stop();
  end
endmodule : tb_watchdog_counter_reset_control
`default_nettype wire
